// *** rtl/sswp_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module sswp_core (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic        wp_n,
  output logic             so,
  output logic             so_oe,
  output logic [7:0]       opcode,
  output logic             opcode_valid,
  output logic             cs_rise,
  input  wire logic [18:0] chk_addr,
  output logic             array_write_ok,
  output logic             status_write_ok,
  output logic [7:0]       status_byte,
  output logic [2:0]       nv_store_data,
  output logic             nv_store_we,
  input  wire logic [2:0]  nv_load_data,
  input  wire logic        nv_load_valid
);
  import sswp_pkg::*;

  // Every link pin crosses two flops before use.
  logic [1:0] cs_sync_q, sck_sync_q, si_sync_q, wp_sync_q;
  logic       cs_q, sck_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q  <= 2'h0;
      wp_sync_q  <= 2'h3;
      cs_q       <= 1'b1;
      sck_q      <= 1'b0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[0], cs_n};
      sck_sync_q <= {sck_sync_q[0], sck};
      si_sync_q  <= {si_sync_q[0], si};
      wp_sync_q  <= {wp_sync_q[0], wp_n};
      cs_q       <= cs_sync_q[1];
      sck_q      <= sck_sync_q[1];
    end
  end

  logic cs_lo, cs_fall, sck_rise, sck_fall, wp_lo;
  assign cs_lo    = !cs_sync_q[1];
  assign cs_fall  = cs_q && !cs_sync_q[1];
  assign cs_rise  = !cs_q && cs_sync_q[1];
  assign sck_rise = cs_lo && !sck_q && sck_sync_q[1];
  assign sck_fall = cs_lo && sck_q && !sck_sync_q[1];
  assign wp_lo    = !wp_sync_q[1];

  function automatic logic op_known(input logic [7:0] op);
    case (op)
      OP_LATCH_ENABLE, OP_LATCH_DISABLE, OP_READ_STATUS, OP_WRITE_STATUS,
      OP_ARRAY_WRITE, OP_ARRAY_READ, OP_FAST_READ, OP_SPECIAL_WRITE,
      OP_SPECIAL_READ, OP_READ_ID, OP_UNIQUE_ID, OP_SERIAL_WRITE,
      OP_SERIAL_READ, OP_DEEP_SLEEP, OP_HIBERNATE: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction

  function automatic logic op_clears_latch(input logic [7:0] op);
    op_clears_latch = (op == OP_LATCH_DISABLE) || (op == OP_WRITE_STATUS)
      || (op == OP_ARRAY_WRITE) || (op == OP_SPECIAL_WRITE)
      || (op == OP_SERIAL_WRITE);
  endfunction

  sswp_state_t state_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic        byte_done;
  logic        pin_protect_enable_q;
  logic [1:0]  block_protect_q;
  logic        write_latch_flag_q;
  logic        wsr_taken_q;
  assign shift_d   = {shift_q[6:0], si_sync_q[1]};
  assign byte_done = sck_rise && (bit_cnt_q == BIT_COUNT_LAST);

  // Status byte assembled with fixed bits; bit 0 never busy.
  always_comb
  begin
    status_byte                  = 8'h00;
    status_byte[BIT_FIXED_ONE]   = 1'b1;
    status_byte[BIT_PIN_PROTECT] = pin_protect_enable_q;
    status_byte[BIT_BP_HI]       = block_protect_q[1];
    status_byte[BIT_BP_LO]       = block_protect_q[0];
    status_byte[BIT_WRITE_LATCH] = write_latch_flag_q;
  end

  // Pin ignored unless enabled; pin never gates the array.
  assign status_write_ok = write_latch_flag_q
    && !(pin_protect_enable_q && wp_lo);

  always_comb
  begin
    unique case (block_protect_q)
      BP_NONE:    array_write_ok = write_latch_flag_q;
      BP_QUARTER: array_write_ok = write_latch_flag_q
                                   && (chk_addr < ADDR_QUARTER);
      BP_HALF:    array_write_ok = write_latch_flag_q
                                   && (chk_addr < ADDR_HALF);
      BP_ALL:     array_write_ok = 1'b0;
    endcase
  end

  // Opcode framing and byte sequencing.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= ST_OPCODE;
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
      opcode    <= 8'h00;
      opcode_valid <= 1'b0;
    end
    else
    begin
      opcode_valid <= 1'b0;
      if (cs_fall || !cs_lo)
      begin
        state_q   <= ST_OPCODE;
        bit_cnt_q <= 3'h0;
      end
      else if (sck_rise)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= shift_d;
        if (byte_done)
        begin
          unique case (state_q)
            ST_OPCODE:
            begin
              opcode       <= shift_d;
              opcode_valid <= op_known(shift_d);
              if (shift_d == OP_READ_STATUS)
                state_q <= ST_RSDATA;
              else if (shift_d == OP_WRITE_STATUS)
                state_q <= ST_WSDATA;
              else
                state_q <= ST_IGNORE;
            end
            ST_WSDATA: state_q <= ST_IGNORE;
            ST_RSDATA: state_q <= ST_RSDATA;
            ST_IGNORE: state_q <= ST_IGNORE;
          endcase
        end
      end
    end
  end

  // Status read output; repeats the byte while clocks continue.
  logic [7:0] out_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_q <= 8'h00;
      so_oe <= 1'b0;
    end
    else if (!cs_lo)
      so_oe <= 1'b0;
    else if (state_q == ST_RSDATA && sck_fall)
    begin
      so_oe <= 1'b1;
      if (bit_cnt_q == 3'h0)
        out_q <= status_byte;
      else
        out_q <= {out_q[6:0], 1'b0};
    end
  end
  assign so = out_q[7];

  // Nonvolatile fields: loaded from storage, saved on each accepted write.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_protect_enable_q <= RESET_NV[2];
      block_protect_q      <= RESET_NV[1:0];
      wsr_taken_q          <= 1'b0;
      nv_store_we          <= 1'b0;
      nv_store_data        <= RESET_NV;
    end
    else
    begin
      nv_store_we <= 1'b0;
      if (cs_fall)
        wsr_taken_q <= 1'b0;
      if (nv_load_valid)
      begin
        pin_protect_enable_q <= nv_load_data[2];
        block_protect_q      <= nv_load_data[1:0];
      end
      else if (state_q == ST_WSDATA && byte_done && status_write_ok)
      begin
        pin_protect_enable_q <= shift_d[BIT_PIN_PROTECT];
        block_protect_q      <= shift_d[BIT_BP_HI:BIT_BP_LO];
        nv_store_data <= {shift_d[BIT_PIN_PROTECT],
                          shift_d[BIT_BP_HI:BIT_BP_LO]};
        nv_store_we   <= 1'b1;
        wsr_taken_q   <= 1'b1;
      end
    end
  end

  // Latch: set only by the enable opcode, cleared at the end of a disable or write frame.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      write_latch_flag_q <= 1'b0;
    else if (cs_rise && op_known(opcode) && op_clears_latch(opcode)
             && state_q != ST_OPCODE)
      write_latch_flag_q <= 1'b0;
    else if (cs_rise && opcode == OP_LATCH_ENABLE && state_q != ST_OPCODE)
      write_latch_flag_q <= 1'b1;
  end

  chk_fixed_bits: assert property (
    @(posedge clk) disable iff (!arst_n)
    status_byte[6] && !status_byte[0] && status_byte[5:4] == 2'h0)
    else $error("fixed status bits wrong");
  chk_latch_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cs_rise && state_q == ST_IGNORE && opcode == OP_LATCH_DISABLE)
    |=> !write_latch_flag_q)
    else $error("latch not cleared by disable");
  chk_latch_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cs_rise && state_q == ST_IGNORE && opcode == OP_LATCH_ENABLE)
    |=> write_latch_flag_q)
    else $error("latch not set by enable");
  chk_latch_only_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(write_latch_flag_q) |-> $past(cs_rise)
    && $past(opcode) == OP_LATCH_ENABLE)
    else $error("latch set without enable");
  chk_pin_refuse: assert property (
    @(posedge clk) disable iff (!arst_n)
    (pin_protect_enable_q && wp_lo) |-> !status_write_ok)
    else $error("status write allowed under pin");
  chk_pin_ignored: assert property (
    @(posedge clk) disable iff (!arst_n)
    !pin_protect_enable_q |-> status_write_ok == write_latch_flag_q)
    else $error("pin not ignored");
  chk_refused_keep: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_WSDATA && byte_done && !status_write_ok && !nv_load_valid)
    |=> $stable(block_protect_q) && $stable(pin_protect_enable_q))
    else $error("refused write changed status");
  chk_wsr_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cs_rise && wsr_taken_q) |=> !write_latch_flag_q)
    else $error("status write kept latch");
  chk_all_protect: assert property (
    @(posedge clk) disable iff (!arst_n)
    (block_protect_q == BP_ALL || !write_latch_flag_q) |-> !array_write_ok)
    else $error("array write allowed while protected");
  chk_ignore_quiet: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_q == ST_IGNORE |-> !so_oe)
    else $error("output enabled for ignored frame");
  cov_status_write: cover property (@(posedge clk) disable iff (!arst_n)
    nv_store_we);
  cov_status_read: cover property (@(posedge clk) disable iff (!arst_n)
    so_oe && state_q == ST_RSDATA);
  cov_refused: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == ST_WSDATA && byte_done && !status_write_ok);
endmodule
`default_nettype wire

// *** rtl/sswp_pkg.sv ***
package sswp_pkg;
  localparam logic [7:0] OP_LATCH_ENABLE  = 8'h06;
  localparam logic [7:0] OP_LATCH_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0b;
  localparam logic [7:0] OP_SPECIAL_WRITE = 8'h42;
  localparam logic [7:0] OP_SPECIAL_READ  = 8'h4b;
  localparam logic [7:0] OP_READ_ID       = 8'h9f;
  localparam logic [7:0] OP_UNIQUE_ID     = 8'h4c;
  localparam logic [7:0] OP_SERIAL_WRITE  = 8'hc2;
  localparam logic [7:0] OP_SERIAL_READ   = 8'hc3;
  localparam logic [7:0] OP_DEEP_SLEEP    = 8'hba;
  localparam logic [7:0] OP_HIBERNATE     = 8'hb9;
  localparam int         BIT_PIN_PROTECT  = 7;
  localparam int         BIT_FIXED_ONE    = 6;
  localparam int         BIT_BP_HI        = 3;
  localparam int         BIT_BP_LO        = 2;
  localparam int         BIT_WRITE_LATCH  = 1;
  localparam logic [1:0] BP_NONE          = 2'h0;
  localparam logic [1:0] BP_QUARTER       = 2'h1;
  localparam logic [1:0] BP_HALF          = 2'h2;
  localparam logic [1:0] BP_ALL           = 2'h3;
  localparam logic [18:0] ADDR_QUARTER    = 19'h60000;
  localparam logic [18:0] ADDR_HALF       = 19'h40000;
  localparam logic [2:0] RESET_NV         = 3'h0;
  localparam logic [2:0] BIT_COUNT_LAST   = 3'h7;
  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_WSDATA = 4'b0010,
    ST_RSDATA = 4'b0100,
    ST_IGNORE = 4'b1000
  } sswp_state_t;
endpackage

// *** test/spi_status_write_protect_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_status_write_protect_tb;
  import sswp_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n;
  logic        wp_n;
  logic [18:0] chk_addr;
  logic [2:0]  nv_load_data;
  logic        nv_load_valid;
  wire logic   cs_n;
  wire logic   sck;
  wire logic   si;
  logic        so;
  logic        so_oe;
  logic        array_write_ok;
  logic        status_write_ok;
  logic [7:0]  status_byte;
  logic [2:0]  nv_store_data;
  logic [7:0]  r;
  int          mismatches;
  int          comparisons;
  int          oe_cnt;
  int          oe_old;
  logic [18:0] addrs [6];
  logic [7:0]  opcode;
  logic        opcode_valid;
  logic        cs_rise;
  logic        nv_store_we;
  int          vld_cnt;
  int          rise_cnt;
  int          we_cnt;
  int          vld_old;
  int          rise_old;
  int          we_old;
  logic [7:0]  wr_ops [3];

  always #4 clk = ~clk;
  // Pulse outputs are counted so that a test can compare counts later.
  always @(posedge clk)
  begin
    if (so_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
    if (opcode_valid === 1'b1)
      vld_cnt <= vld_cnt + 1;
    if (cs_rise === 1'b1)
      rise_cnt <= rise_cnt + 1;
    if (nv_store_we === 1'b1)
      we_cnt <= we_cnt + 1;
  end

  sswp_spi_master m (.cs_n(cs_n), .sck(sck), .si(si), .so(so));

  sswp_core uut (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .opcode(opcode),
    .opcode_valid(opcode_valid),
    .cs_rise(cs_rise), .chk_addr(chk_addr), .array_write_ok(array_write_ok),
    .status_write_ok(status_write_ok), .status_byte(status_byte),
    .nv_store_data(nv_store_data), .nv_store_we(nv_store_we),
    .nv_load_data(nv_load_data), .nv_load_valid(nv_load_valid)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic [7:0] code);
    m.frame(code, 8'h00, 1'b0, r);
  endtask

  task automatic write_status_cmd(input logic [7:0] dat);
    m.frame(OP_WRITE_STATUS, dat, 1'b1, r);
  endtask

  task automatic rd(input logic [7:0] exp);
    m.frame(OP_READ_STATUS, 8'h00, 1'b1, r);
    check(r, exp);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #500us;
    mismatches++;
    final_report();
  end

  initial
  begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    chk_addr = 19'h00000;
    nv_load_data = 3'h0;
    nv_load_valid = 1'b0;
    addrs = '{19'h00000, 19'h3ffff, 19'h40000, 19'h5ffff, 19'h60000,
              19'h7ffff};
    wr_ops = '{OP_ARRAY_WRITE, OP_SPECIAL_WRITE, OP_SERIAL_WRITE};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(status_byte, 8'h40);
    rd(8'h40);
    $display("test reset done");
    vld_old = vld_cnt;
    op(OP_LATCH_ENABLE);
    check(status_byte, 8'h42);
    check(opcode, OP_LATCH_ENABLE);
    check(8'(vld_cnt - vld_old), 8'h01);
    rd(8'h42);
    check(8'(so_oe), 8'h00);
    op(OP_LATCH_DISABLE);
    rd(8'h40);
    write_status_cmd(8'h0c);
    check(status_byte, 8'h40);
    foreach (wr_ops[i])
    begin
      op(OP_LATCH_ENABLE);
      op(wr_ops[i]);
      check(status_byte, 8'h40);
    end
    op(OP_LATCH_ENABLE);
    op(OP_ARRAY_READ);
    check(status_byte, 8'h42);
    op(OP_LATCH_DISABLE);
    check(status_byte, 8'h40);
    $display("test latch done");
    for (int bp = 0; bp < 4; bp++)
    begin
      @(posedge clk) wp_n <= 1'b0;
      op(OP_LATCH_ENABLE);
      check(8'(status_write_ok), 8'h01);
      write_status_cmd({4'h0, 2'(bp), 2'b11});
      check(status_byte, 8'h40 | 8'(bp << 2));
      op(OP_LATCH_ENABLE);
      foreach (addrs[i])
      begin
        @(posedge clk) chk_addr <= addrs[i];
        @(negedge clk);
        check(8'(array_write_ok), 8'(!(bp == 3 ||
              (bp == 2 && addrs[i] >= ADDR_HALF) ||
              (bp == 1 && addrs[i] >= ADDR_QUARTER))));
      end
      op(OP_LATCH_DISABLE);
      check(8'(array_write_ok), 8'h00);
    end
    $display("test block protect done");
    @(posedge clk) wp_n <= 1'b1;
    op(OP_LATCH_ENABLE);
    we_old = we_cnt;
    write_status_cmd(8'h80);
    check(status_byte, 8'hc0);
    check(8'(nv_store_data), 8'h04);
    check(8'(we_cnt - we_old), 8'h01);
    @(posedge clk) wp_n <= 1'b0;
    op(OP_LATCH_ENABLE);
    check(8'(status_write_ok), 8'h00);
    check(8'(array_write_ok), 8'h01);
    we_old = we_cnt;
    write_status_cmd(8'h0c);
    check(status_byte & 8'hfd, 8'hc0);
    check(8'(we_cnt - we_old), 8'h00);
    @(posedge clk) wp_n <= 1'b1;
    op(OP_LATCH_ENABLE);
    check(8'(status_write_ok), 8'h01);
    $display("test pin protect done");
    oe_old = oe_cnt;
    vld_old = vld_cnt;
    rise_old = rise_cnt;
    m.frame(8'h77, OP_READ_STATUS, 1'b1, r);
    check(8'(oe_cnt - oe_old), 8'h00);
    check(opcode, 8'h77);
    check(8'(vld_cnt - vld_old), 8'h00);
    check(8'(rise_cnt - rise_old), 8'h01);
    $display("test invalid opcode done");
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check(status_byte, 8'h40);
    @(posedge clk) nv_load_data <= 3'h5;
    nv_load_valid <= 1'b1;
    @(posedge clk) nv_load_valid <= 1'b0;
    repeat (2) @(negedge clk);
    check(status_byte, 8'hc4);
    $display("test nonvolatile done");
    final_report();
  end
endmodule
`default_nettype wire

// *** test/sswp_spi_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module sswp_spi_master (
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  localparam realtime HALF = 62.5;

  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Mode 0 frame, MSb first: opcode and an optional second byte.
  // The link clock is free of the system clock, so its phase drifts.
  task automatic frame(input logic [7:0] op, input logic [7:0] dat,
                       input bit two, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < (two ? 16 : 8); i++)
    begin
      si = sh[15 - i];
      #HALF sck = 1'b1;
      rd = {rd[6:0], so};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // A released data line must not keep showing the last bit.
    si = ~si;
    #(4 * HALF);
  endtask
endmodule
`default_nettype wire
